// ==== verilog/wwdc_cfg.svh ====
`ifndef WWDC_CFG_SVH
`define WWDC_CFG_SVH

// ==========================================================
// register indices (byte address is four times the index)
`define WWDC_IDX_CTRL      8'h0c
`define WWDC_IDX_TEST0     8'h0d
`define WWDC_IDX_TEST1     8'h0e
`define WWDC_IDX_SERVICE   8'h0f
`define WWDC_IDX_CLKSEL    8'h10
`define WWDC_IDX_STATUS    8'h11
`define WWDC_IDX_MASK      8'h12

// ==========================================================
// watchdog_control fields
`define WWDC_CTRL_WIN_BIT  7
`define WWDC_CTRL_FRZ_BIT  6
`define WWDC_CTRL_WMSK_BIT 5
`define WWDC_CTRL_RATE_LSB 0
`define WWDC_CTRL_RATE_W   3
`define WWDC_CTRL_RST      8'h00

// ==========================================================
// clock select fields
`define WWDC_CSEL_LO_BIT   0
`define WWDC_CSEL_HI_BIT   1
`define WWDC_CSEL_RST      2'h0

// ==========================================================
// status / mask bits
`define WWDC_EV_TIMEOUT    0
`define WWDC_EV_BADKEY     1
`define WWDC_EV_EARLY      2
`define WWDC_EV_W          3
`define WWDC_EV_RST        3'h0

// ==========================================================
// service keys
`define WWDC_KEY_FIRST     8'h55
`define WWDC_KEY_SECOND    8'haa

// ==========================================================
// timeout exponents, codes 1..7, one table per state of clock-select bit 1
`define WWDC_EXP_LO  '{5'h00, 5'h0e, 5'h10, 5'h12, 5'h14, 5'h16, 5'h17, 5'h18}
`define WWDC_EXP_HI  '{5'h00, 5'h07, 5'h09, 5'h0b, 5'h0d, 5'h0f, 5'h10, 5'h11}
`define WWDC_EXP_FORCED    5'h18

`endif

// ==== verilog/wwdc_pkg.sv ====
package wwdc_pkg;

	// ==========================================================
	// control register contents
	typedef struct packed {
		logic       win;
		logic       frz;
		logic [2:0] rate;
	} wwdc_ctrl_s;

	// ==========================================================
	// synchronised external levels
	typedef struct packed {
		logic dbg;
		logic spec;
		logic aclk;
		logic xtal;
		logic rc;
	} wwdc_pins_s;

endpackage : wwdc_pkg

// ==== verilog/wwdc_tmr.sv ====
`include "wwdc_cfg.svh"

module wwdc_tmr #(
	parameter int W = 25
) (
	// clock and reset
	input  wire logic         sys_clk,
	input  wire logic         srst,
	input  wire logic         ce,
	// control
	input  wire logic         tick,
	input  wire logic         run,
	input  wire logic         restart,
	input  wire logic [4:0]   exp_sel,
	// state
	output logic [W-1:0]      cnt_r,
	output logic              expire,
	output logic              in_window
);

	logic [W-1:0] limit;
	logic [W-1:0] win_start;
	logic [W-1:0] cnt_nxt;

	// ==========================================================
	// period and last-quarter window
	assign limit     = W'(1) << exp_sel;
	assign win_start = limit - (limit >> 2);
	assign in_window = cnt_r >= win_start;
	assign expire    = run & tick & (cnt_r == limit - W'(1));

	assign cnt_nxt = restart ? '0 :
		(run & tick) ? cnt_r + W'(1) : cnt_r;

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			cnt_r <= '0;
		end else if (ce) begin
			cnt_r <= cnt_nxt;
		end
	end

endmodule : wwdc_tmr

// ==== verilog/wwdc_top.sv ====
`include "wwdc_cfg.svh"

module wwdc_top #(
	parameter int SHORTEN = 0
) (
	// clock, reset, enable
	input  wire logic         sys_clk,
	input  wire logic         srst,
	input  wire logic         ce,
	// wishbone slave
	input  wire logic         wb_cyc_i,
	input  wire logic         wb_stb_i,
	input  wire logic         wb_we_i,
	input  wire logic [9:0]   wb_adr_i,
	input  wire logic [3:0]   wb_sel_i,
	input  wire logic [31:0]  wb_dat_i,
	output logic [31:0]       wb_dat_o,
	output logic              wb_ack_o,
	// asynchronous pins
	input  wire logic         internal_rc_clock,
	input  wire logic         crystal_clock,
	input  wire logic         autonomous_clock,
	input  wire logic         background_debug,
	input  wire logic         special_mode,
	// results
	output logic              sys_reset_req_r,
	output logic              rti_halt_r,
	output logic              irq_r
);

	localparam int         CW = 25;
	localparam logic [4:0] EXP_LO [8] = `WWDC_EXP_LO;
	localparam logic [4:0] EXP_HI [8] = `WWDC_EXP_HI;

	// ==========================================================
	// pin synchronisers
	wwdc_pkg::wwdc_pins_s pins_in;
	logic [4:0]           sync1_r;
	logic [4:0]           sync2_r;
	logic [4:0]           sync3_r;
	wwdc_pkg::wwdc_pins_s pin_s;
	wwdc_pkg::wwdc_pins_s pin_rise;

	assign pins_in = '{dbg: background_debug, spec: special_mode,
		aclk: autonomous_clock, xtal: crystal_clock,
		rc: internal_rc_clock};

	genvar gi;
	generate
		for (gi = 0; gi < 5; gi++) begin : g_sync
			always_ff @(posedge sys_clk) begin
				if (srst) begin
					sync1_r[gi] <= 1'b0;
					sync2_r[gi] <= 1'b0;
					sync3_r[gi] <= 1'b0;
				end else if (ce) begin
					sync1_r[gi] <= pins_in[gi];
					sync2_r[gi] <= sync1_r[gi];
					sync3_r[gi] <= sync2_r[gi];
				end
			end
		end
	endgenerate

	assign pin_s    = sync2_r;
	assign pin_rise = sync2_r & ~sync3_r;

	// ==========================================================
	// bus decode
	logic       acc;
	logic       bus_wr;
	logic       bus_rd;
	logic [7:0] idx;
	logic [7:0] d;
	logic       sel_ctrl;
	logic       sel_test;
	logic       sel_srv;
	logic       sel_csel;
	logic       sel_stat;
	logic       sel_mask;

	assign acc      = wb_cyc_i & wb_stb_i & ~wb_ack_o;
	assign bus_wr   = acc & wb_we_i & wb_sel_i[0];
	assign bus_rd   = acc & ~wb_we_i;
	assign idx      = wb_adr_i[9:2];
	assign d        = wb_dat_i[7:0];
	assign sel_ctrl = idx == `WWDC_IDX_CTRL;
	assign sel_test = (idx == `WWDC_IDX_TEST0) |
		(idx == `WWDC_IDX_TEST1);
	assign sel_srv  = idx == `WWDC_IDX_SERVICE;
	assign sel_csel = idx == `WWDC_IDX_CLKSEL;
	assign sel_stat = idx == `WWDC_IDX_STATUS;
	assign sel_mask = idx == `WWDC_IDX_MASK;

	// ==========================================================
	// control register
	wwdc_pkg::wwdc_ctrl_s ctrl_r;
	wwdc_pkg::wwdc_ctrl_s ctrl_nxt;
	logic                 once_r;
	logic                 once_nxt;
	logic [1:0]           csel_r;
	logic [1:0]           csel_nxt;
	logic                 wr_ctrl;
	logic                 wmask;
	logic                 cfg_ok;
	logic                 rate_ok;
	logic                 ctrl_restart;
	logic                 csel_chg;
	logic                 en;

	assign wr_ctrl = bus_wr & sel_ctrl;
	assign wmask   = d[`WWDC_CTRL_WMSK_BIT];
	assign cfg_ok  = wr_ctrl & ~wmask & (pin_s.spec | ~once_r);
	// zero rate in normal mode leaves the old rate but uses the write
	assign rate_ok = cfg_ok & (pin_s.spec |
		(d[2:0] != 3'h0));

	assign ctrl_nxt.rate = rate_ok ? d[2:0] : ctrl_r.rate;
	assign ctrl_nxt.win  = ~cfg_ok ? ctrl_r.win :
		pin_s.spec ? d[`WWDC_CTRL_WIN_BIT] :
		(ctrl_r.win | d[`WWDC_CTRL_WIN_BIT]);
	assign ctrl_nxt.frz  = ~wr_ctrl ? ctrl_r.frz :
		pin_s.spec ? d[`WWDC_CTRL_FRZ_BIT] :
		(ctrl_r.frz | d[`WWDC_CTRL_FRZ_BIT]);
	assign once_nxt = once_r | (wr_ctrl & ~wmask & ~pin_s.spec);

	assign ctrl_restart = wr_ctrl & (pin_s.spec |
		(cfg_ok & ((d[2:0] != 3'h0) | d[`WWDC_CTRL_WIN_BIT])) |
		(~ctrl_r.frz & d[`WWDC_CTRL_FRZ_BIT]));
	assign csel_nxt = (bus_wr & sel_csel) ? d[1:0] : csel_r;
	assign csel_chg = csel_nxt != csel_r;
	assign en       = ctrl_r.rate != 3'h0;

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			ctrl_r <= 5'(`WWDC_CTRL_RST);
			once_r <= 1'b0;
			csel_r <= `WWDC_CSEL_RST;
		end else if (ce) begin
			ctrl_r <= ctrl_nxt;
			once_r <= once_nxt;
			csel_r <= csel_nxt;
		end
	end

	// ==========================================================
	// watchdog clock selection
	logic aclk_half_r;
	logic tick;

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			aclk_half_r <= 1'b0;
		end else if (ce && pin_rise.aclk) begin
			aclk_half_r <= ~aclk_half_r;
		end
	end

	assign tick = csel_r[`WWDC_CSEL_HI_BIT] ?
		(pin_rise.aclk & aclk_half_r) :
		csel_r[`WWDC_CSEL_LO_BIT] ? pin_rise.xtal :
		pin_rise.rc;

	// ==========================================================
	// period selection and mode
	logic       forced;
	logic       frozen;
	logic       eff_win;
	logic [4:0] exp_raw;
	logic [4:0] exp_sel;

	assign forced  = en & pin_s.dbg & ~ctrl_r.frz & pin_s.spec;
	assign frozen  = ctrl_r.frz & pin_s.dbg;
	assign eff_win = ctrl_r.win & ~forced;
	assign exp_raw = forced ? `WWDC_EXP_FORCED :
		csel_r[`WWDC_CSEL_HI_BIT] ? EXP_HI[ctrl_r.rate] :
		EXP_LO[ctrl_r.rate];
	assign exp_sel = 5'(exp_raw - 5'(SHORTEN));

	// ==========================================================
	// service register
	logic srv_wr;
	logic key1;
	logic key2;
	logic early;
	logic bad;
	logic svc_done;
	logic armed_r;
	logic in_window;
	logic expire;
	logic restart;
	logic [CW-1:0] cnt;

	assign srv_wr   = bus_wr & sel_srv & en;
	assign key1     = d == `WWDC_KEY_FIRST;
	assign key2     = d == `WWDC_KEY_SECOND;
	assign early    = eff_win & ~in_window;
	assign bad      = srv_wr & (~(key1 | key2) | early);
	assign svc_done = srv_wr & key2 & armed_r & ~early;
	assign restart  = svc_done | ctrl_restart | csel_chg | ~en;

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			armed_r <= 1'b0;
		end else if (ce) begin
			if (restart) begin
				armed_r <= 1'b0;
			end else if (srv_wr && key1 && !early) begin
				armed_r <= 1'b1;
			end
		end
	end

	wwdc_tmr #(
		.W (CW)
	) u_tmr (
		.sys_clk   (sys_clk),
		.srst      (srst),
		.ce        (ce),
		.tick      (tick),
		.run       (en & ~frozen),
		.restart   (restart),
		.exp_sel   (exp_sel),
		.cnt_r     (cnt),
		.expire    (expire),
		.in_window (in_window)
	);

	// ==========================================================
	// events, interrupt, reset request
	logic [`WWDC_EV_W-1:0] ev;
	logic [`WWDC_EV_W-1:0] stat_r;
	logic [`WWDC_EV_W-1:0] stat_nxt;
	logic [`WWDC_EV_W-1:0] mask_r;
	logic                  rd_stat;

	assign ev[`WWDC_EV_TIMEOUT] = expire;
	assign ev[`WWDC_EV_BADKEY]  = srv_wr & ~(key1 | key2);
	assign ev[`WWDC_EV_EARLY]   = srv_wr & early;
	assign rd_stat  = bus_rd & sel_stat;
	assign stat_nxt = (rd_stat ? '0 : stat_r) | ev;

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			stat_r          <= `WWDC_EV_RST;
			mask_r          <= `WWDC_EV_RST;
			irq_r           <= 1'b0;
			sys_reset_req_r <= 1'b0;
			rti_halt_r      <= 1'b0;
		end else if (ce) begin
			stat_r          <= stat_nxt;
			if (bus_wr && sel_mask) begin
				mask_r      <= d[`WWDC_EV_W-1:0];
			end
			irq_r           <= |(stat_nxt & mask_r);
			sys_reset_req_r <= sys_reset_req_r | expire | bad;
			rti_halt_r      <= frozen;
		end
	end

	// ==========================================================
	// read data and acknowledge
	logic [7:0] rdata;

	assign rdata = sel_ctrl ? {ctrl_r.win, ctrl_r.frz, 3'h0,
		ctrl_r.rate} :
		sel_csel ? {6'h00, csel_r} :
		sel_stat ? {5'h00, stat_r} :
		sel_mask ? {5'h00, mask_r} :
		8'h00;

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0000_0000;
		end else if (ce) begin
			wb_ack_o <= acc;
			if (bus_rd) begin
				wb_dat_o <= {24'h00_0000, rdata};
			end
		end
	end

	// ==========================================================
	// checks
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (srst);

	sequence s_first_key;
		ce && srv_wr && key1 && !early && !restart;
	endsequence

	sequence s_second_key;
		ce && srv_wr && key2 && !early;
	endsequence

	timeout_reset_a: assert property (
		ce && expire |=> sys_reset_req_r [*2])
		else $error("expiry did not raise reset");

	bad_key_a: assert property (
		ce && srv_wr && !key1 && !key2 |=> sys_reset_req_r)
		else $error("wrong key did not raise reset");

	early_service_a: assert property (
		ce && srv_wr && eff_win && !in_window |=> sys_reset_req_r)
		else $error("early service did not raise reset");

	key_arm_a: assert property (
		s_first_key |=> armed_r)
		else $error("first key did not arm service");

	key_pair_a: assert property (
		s_second_key ##0 armed_r |=> cnt == '0)
		else $error("key pair did not restart counter");

	debug_freeze_a: assert property (
		ce && frozen && !restart |=> $stable(cnt) && rti_halt_r)
		else $error("counter ran while frozen");

	write_mask_a: assert property (
		ce && wr_ctrl && wmask |=> $stable(ctrl_r.rate) &&
		$stable(ctrl_r.win) && once_r == $past(once_r))
		else $error("masked write changed config");

	write_once_a: assert property (
		ce && wr_ctrl && once_r && !pin_s.spec |=> $stable(ctrl_r.rate))
		else $error("second normal write took effect");

	disabled_srv_a: assert property (
		ce && acc && sel_srv && !en && !sys_reset_req_r
		|=> !sys_reset_req_r && (!$past(bus_rd) || wb_dat_o == 32'h0))
		else $error("disabled service write acted");

	test_zero_a: assert property (
		ce && bus_rd && sel_test |=> wb_ack_o && wb_dat_o == 32'h0)
		else $error("test register read nonzero");

	clk_sel_a: assert property (
		ce && csel_chg |=> cnt == '0)
		else $error("clock select change kept count");

endmodule : wwdc_top

// ==== tb/wwdc_tb.sv ====
`include "wwdc_cfg.svh"

module testbench;
	timeunit 1ns;
	timeprecision 1ps;

	// ==========================================================
	// register indices and keys
	localparam logic [7:0] a_ct = `WWDC_IDX_CTRL;
	localparam logic [7:0] a_t0 = `WWDC_IDX_TEST0;
	localparam logic [7:0] a_t1 = `WWDC_IDX_TEST1;
	localparam logic [7:0] a_sv = `WWDC_IDX_SERVICE;
	localparam logic [7:0] a_cs = `WWDC_IDX_CLKSEL;
	localparam logic [7:0] a_st = `WWDC_IDX_STATUS;
	localparam logic [7:0] a_mk = `WWDC_IDX_MASK;
	localparam logic [7:0] k1   = `WWDC_KEY_FIRST;
	localparam logic [7:0] k2   = `WWDC_KEY_SECOND;

	// ==========================================================
	// signals
	logic        sys_clk = 1'b0;
	logic        srst    = 1'b1;
	logic        cyc     = 1'b0;
	logic        stb     = 1'b0;
	logic        we      = 1'b0;
	logic [9:0]  adr     = 10'h000;
	logic [3:0]  sel     = 4'h0;
	logic [31:0] wdat    = 32'h0;
	logic [2:0]  pin_r   = 3'h0;
	logic        dbg     = 1'b0;
	logic        spec    = 1'b0;
	logic        ce      = 1'b1;
	logic [31:0] rdat_w;
	logic        ack_w;
	logic        rst_req;
	logic        halt;
	logic        irq;
	logic [31:0] rd;
	int          n_errors        = 0;
	int          samples_checked = 0;

	always #4 sys_clk = ~sys_clk;

	wwdc_top #(.SHORTEN(10)) dut (
		.sys_clk           (sys_clk),
		.srst              (srst),
		.ce                (ce),
		.wb_cyc_i          (cyc),
		.wb_stb_i          (stb),
		.wb_we_i           (we),
		.wb_adr_i          (adr),
		.wb_sel_i          (sel),
		.wb_dat_i          (wdat),
		.wb_dat_o          (rdat_w),
		.wb_ack_o          (ack_w),
		.internal_rc_clock (pin_r[0]),
		.crystal_clock     (pin_r[1]),
		.autonomous_clock  (pin_r[2]),
		.background_debug  (dbg),
		.special_mode      (spec),
		.sys_reset_req_r   (rst_req),
		.rti_halt_r        (halt),
		.irq_r             (irq)
	);

	// ==========================================================
	// helpers
	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			n_errors++;
			$display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
		end
	endtask : cmp

	// one classic cycle, held until ack is sampled high
	task automatic wb(input logic w, input logic [7:0] idx,
			input logic [7:0] d, input logic [3:0] s = 4'h1);
		int k;
		k = 0;
		cyc  <= 1'b1;
		stb  <= 1'b1;
		we   <= w;
		adr  <= {idx, 2'h0};
		sel  <= s;
		wdat <= {24'h0, d};
		do begin
			@(posedge sys_clk);
			k++;
		end while (ack_w !== 1'b1 && k < 20);
		if (k >= 20) n_errors++;
		rd = rdat_w;
		cyc <= 1'b0;
		stb <= 1'b0;
		we  <= 1'b0;
		@(posedge sys_clk);
	endtask : wb

	// n rising edges on watchdog clock pin p
	task automatic tk(input int p, input int n);
		repeat (n) begin
			pin_r[p] <= 1'b1;
			repeat (2) @(posedge sys_clk);
			pin_r[p] <= 1'b0;
			repeat (2) @(posedge sys_clk);
		end
	endtask : tk

	task automatic rq(input logic e);
		repeat (6) @(posedge sys_clk);
		cmp({31'h0, rst_req}, {31'h0, e});
	endtask : rq

	task automatic rst;
		srst <= 1'b1;
		repeat (8) @(posedge sys_clk);
		srst <= 1'b0;
		repeat (4) @(posedge sys_clk);
	endtask : rst

	task automatic done(input string s);
		$display("test %0s done, mismatches so far %0d", s, n_errors);
	endtask : done

	// expiry lands exactly after the selected number of edges
	task automatic per(input logic [7:0] cs, input logic [7:0] code,
			input int p, input int edges);
		rst;
		wb(1, a_cs, cs);
		wb(1, a_ct, code);
		tk(p, edges - 1);
		rq(0);
		tk(p, 1);
		rq(1);
	endtask : per

	task automatic tally_and_finish;
		$display("comparisons %0d mismatches %0d", samples_checked, n_errors);
		if (n_errors == 0 && samples_checked > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : tally_and_finish

	initial begin
		repeat (60000) @(posedge sys_clk);
		n_errors++;
		tally_and_finish;
	end

	// ==========================================================
	// tests
	initial begin
		logic [7:0] ix [8];
		int eh [4];
		ix = '{a_ct, a_t0, a_t1, a_sv, a_cs, a_st, a_mk, 8'h30};
		eh = '{3, 5, 6, 7};
		rst;
		foreach (ix[i]) begin
			wb(0, ix[i], 8'h00);
			cmp(rd, 32'h0);
		end
		wb(1, a_sv, 8'h13);
		tk(0, 40);
		rq(0);
		wb(1, a_ct, 8'h01, 4'h2);
		wb(0, a_ct, 8'h00);
		cmp(rd, 32'h0);
		wb(1, a_ct, 8'h01);
		repeat (3) begin
			tk(0, 12);
			wb(1, a_sv, k1);
			wb(1, a_sv, k2);
		end
		rq(0);
		wb(1, a_ct, 8'h87);
		wb(0, a_ct, 8'h00);
		cmp(rd, 32'h01);
		wb(1, a_ct, 8'h67);
		wb(0, a_ct, 8'h00);
		cmp(rd, 32'h41);
		wb(1, a_sv, 8'h13);
		rq(1);
		cmp({31'h0, irq}, 32'h0);
		wb(1, a_mk, 8'h02);
		repeat (2) @(posedge sys_clk);
		cmp({31'h0, irq}, 32'h1);
		wb(0, a_st, 8'h00);
		cmp(rd, 32'h2);
		repeat (2) @(posedge sys_clk);
		cmp({31'h0, irq}, 32'h0);
		done("config and keys");

		rst;
		wb(1, a_ct, 8'h81);
		tk(0, 11);
		wb(1, a_sv, k1);
		rq(1);
		wb(0, a_st, 8'h00);
		cmp(rd, 32'h4);
		rst;
		wb(1, a_ct, 8'h81);
		tk(0, 13);
		wb(1, a_sv, k1);
		wb(1, a_sv, k1);
		wb(1, a_sv, k2);
		rq(0);
		wb(1, a_sv, k1);
		rq(1);
		done("window");

		rst;
		wb(1, a_ct, 8'h41);
		dbg <= 1'b1;
		repeat (4) @(posedge sys_clk);
		tk(0, 40);
		rq(0);
		cmp({31'h0, halt}, 32'h1);
		dbg <= 1'b0;
		tk(0, 20);
		rq(1);
		wb(0, a_st, 8'h00);
		cmp(rd, 32'h1);
		rst;
		wb(1, a_ct, 8'h01);
		dbg <= 1'b1;
		tk(0, 20);
		rq(1);
		dbg <= 1'b0;
		done("freeze");

		rst;
		spec <= 1'b1;
		repeat (4) @(posedge sys_clk);
		wb(1, a_ct, 8'h01);
		wb(1, a_ct, 8'h83);
		wb(0, a_ct, 8'h00);
		cmp(rd, 32'h83);
		wb(1, a_t0, 8'hff);
		wb(0, a_t0, 8'h00);
		cmp(rd, 32'h0);
		dbg <= 1'b1;
		repeat (4) @(posedge sys_clk);
		wb(1, a_ct, 8'h81);
		wb(1, a_sv, k1);
		wb(1, a_sv, k2);
		tk(0, 40);
		rq(0);
		dbg  <= 1'b0;
		spec <= 1'b0;
		done("special");

		rst;
		wb(1, a_ct, 8'h01);
		ce <= 1'b0;
		tk(0, 40);
		ce <= 1'b1;
		tk(0, 12);
		wb(1, a_cs, 8'h01);
		tk(1, 12);
		rq(0);
		tk(1, 6);
		rq(1);
		done("clock select");

		for (int c = 1; c <= 5; c++)
			per(8'h00, 8'(c), 0, 1 << (2 + 2 * c));
		foreach (eh[i])
			per(8'h02, 8'(4 + i), 2, 2 << eh[i]);
		done("periods");
		tally_and_finish;
	end
endmodule : testbench
